//--- inc/adc_cfg_pkg.sv
// Constants, field layout and carrier types for the converter setup and alert logic.
// Assumes a 40 MHz core clock and a word-level request port on the link clock.
package adc_cfg_pkg;
  // ==========================================================================
  // Register pointers
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_LOW = 2'h2;
  localparam logic [1:0] PTR_HIGH = 2'h3;
  // ==========================================================================
  // Setup word field positions
  localparam int START_BIT = 15;
  localparam int GAIN_LSB = 9;
  localparam int MODE_BIT = 8;
  localparam int RATE_LSB = 5;
  localparam int STYLE_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int LATCH_BIT = 2;
  localparam int QUE_LSB = 0;
  localparam int LIMIT_LSB = 4;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h8583;
  localparam logic [15:0] LOW_RESET = 16'h8000;
  localparam logic [15:0] HIGH_RESET = 16'h7FFF;
  localparam logic [3:0] LOW_FILL = 4'h0;
  localparam logic [3:0] HIGH_FILL = 4'hF;
  localparam logic [1:0] QUE_OFF = 2'h3;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RDY_PULSE_NS = 8000;
  localparam int RDY_PULSE_CYC = (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {REQ_WRITE, REQ_READ, REQ_ALERT_RESP} req_kind_e;
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_e;
  typedef struct packed {
    req_kind_e kind;
    logic [1:0] ptr;
    logic [15:0] data;
  } link_req_s;
  typedef struct packed {
    logic hit;
    logic [15:0] data;
  } link_rsp_s;
endpackage

//--- verilog/adc_setup_alert.sv
// Setup register, conversion sequencing and threshold/ready alert output.
// Assumes the serial link front end hands over whole words on link_clk and
// that the conversion core pulses conv_done with its 12-bit result on core_clk.
//
// Summary of operation
// - The gain field picks the full-scale span: 6144, 4096, 2048 (reset), 1024, 512 mV, 256 mV for 101 to 111.
// - Mode 0 converts continuously; mode 1 (reset) converts once per request, powered down between.
// - The rate field picks 128/250/490/920/1600 (reset)/2400 samples per second, 3300 for 11x.
// - The style bit picks a single-sided comparator at 0 (reset) or a window comparator at 1.
// - The polarity bit makes the asserted alert level low at 0 (reset) or high at 1.
// - Without latching (reset) the alert releases itself once a result falls below the low limit, or for the window comparator comes back inside the limits.
// - With latching the alert holds until the result is read or an alert response is answered.
// - An alert response while the latched alert is up returns this device's own address.
// - Queue code 11 (reset) disables the comparator and floats the alert pin.
// - Otherwise the alert asserts after 1, 2 or 4 consecutive exceeding results for 00, 01, 10.
// - High limit MSB 1 with low limit MSB 0 turns the pin into a conversion-ready indicator.
// - As ready indicator the pin shows the status bit in single-shot mode, a pulse per result otherwise.
// - Writing 1 to the status bit while idle starts one conversion; it reads 0 while converting.
`timescale 1ns/100ps
module adc_setup_alert (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire adc_cfg_pkg::link_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output adc_cfg_pkg::link_rsp_s rsp,
  input wire logic [6:0] dev_addr,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic converter_on,
  output logic [2:0] gain_range_select,
  output logic [12:0] full_scale_span,
  output logic [2:0] rate_select,
  output logic [11:0] rate_sps,
  output logic alert_o,
  output logic alert_oe
);
  import adc_cfg_pkg::*;

  // ==========================================================================
  // Decoding functions
  function automatic logic [12:0] span_mv(input logic [2:0] g);
    case (g)
      3'h0: span_mv = 13'h1800;
      3'h1: span_mv = 13'h1000;
      3'h2: span_mv = 13'h0800;
      3'h3: span_mv = 13'h0400;
      3'h4: span_mv = 13'h0200;
      default: span_mv = 13'h0100;
    endcase
  endfunction

  function automatic logic [11:0] sps(input logic [2:0] r);
    case (r)
      3'h0: sps = 12'h080;
      3'h1: sps = 12'h0FA;
      3'h2: sps = 12'h1EA;
      3'h3: sps = 12'h398;
      3'h4: sps = 12'h640;
      3'h5: sps = 12'h960;
      default: sps = 12'hCE4;
    endcase
  endfunction

  function automatic logic [2:0] need(input logic [1:0] q);
    case (q)
      2'h0: need = 3'h1;
      2'h1: need = 3'h2;
      default: need = 3'h4;
    endcase
  endfunction

  // ==========================================================================
  // Link side: hold request, toggle to core, wait for toggled answer
  link_req_s lreq_q;
  link_rsp_s rsp_hold_q;
  logic req_tgl_q, lbusy_q, ack_s1_q, ack_s2_q, ack_s3_q, ack_tgl_q, rsp_valid_q;
  link_rsp_s rsp_q;

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      lreq_q <= '0;
      req_tgl_q <= 1'b0;
      lbusy_q <= 1'b0;
      rsp_q <= '0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (req_valid && !lbusy_q) begin
        lreq_q <= req;
        req_tgl_q <= ~req_tgl_q;
        lbusy_q <= 1'b1;
      end else if (ack_s2_q ^ ack_s3_q) begin
        rsp_q <= rsp_hold_q;
        rsp_valid_q <= 1'b1;
        lbusy_q <= 1'b0;
      end
    end
  end

  // Answer toggle synchroniser into the link domain
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  assign req_ready = !lbusy_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;

  // ==========================================================================
  // Core side: request toggle and address strap synchronisers
  logic rq_s1_q, rq_s2_q, rq_s3_q;
  logic [6:0] addr_s1_q, addr_s2_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
      rq_s3_q <= 1'b0;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
    end else begin
      rq_s1_q <= req_tgl_q;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
      addr_s1_q <= dev_addr;
      addr_s2_q <= addr_s1_q;
    end
  end

  logic req_new, wr_cfg, wr_low, wr_high, rd_result, resp_evt, ara_hit;
  logic [15:0] cfg_q, low_q, high_q, result_q;
  conv_state_e state_q;
  logic alert_q, start_req;
  logic [15:0] cfg_rd;

  // Request decode, request word is stable while the link side waits
  always_comb begin
    req_new = rq_s2_q ^ rq_s3_q;
    wr_cfg = 1'b0;
    wr_low = 1'b0;
    wr_high = 1'b0;
    rd_result = 1'b0;
    resp_evt = 1'b0;
    if (req_new && lreq_q.kind == REQ_WRITE && lreq_q.ptr == PTR_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (req_new && lreq_q.kind == REQ_WRITE && lreq_q.ptr == PTR_LOW) begin
      wr_low = 1'b1;
    end else if (req_new && lreq_q.kind == REQ_WRITE && lreq_q.ptr == PTR_HIGH) begin
      wr_high = 1'b1;
    end else if (req_new && lreq_q.kind == REQ_READ && lreq_q.ptr == PTR_RESULT) begin
      rd_result = 1'b1;
    end else if (req_new && lreq_q.kind == REQ_ALERT_RESP) begin
      resp_evt = 1'b1;
    end
  end
  assign ara_hit = resp_evt && alert_q && cfg_q[LATCH_BIT];

  // Status bit reads 0 while converting
  assign cfg_rd = {state_q == CONV_IDLE, cfg_q[14:0]};

  // Answer word and toggle back to the link side
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_hold_q <= '0;
      ack_tgl_q <= 1'b0;
    end else if (req_new) begin
      ack_tgl_q <= ~ack_tgl_q;
      rsp_hold_q.hit <= lreq_q.kind != REQ_ALERT_RESP || ara_hit;
      if (lreq_q.kind == REQ_ALERT_RESP) begin
        rsp_hold_q.data <= {9'h000, addr_s2_q};
      end else if (lreq_q.ptr == PTR_RESULT) begin
        rsp_hold_q.data <= result_q;
      end else if (lreq_q.ptr == PTR_CONFIG) begin
        rsp_hold_q.data <= cfg_rd;
      end else if (lreq_q.ptr == PTR_LOW) begin
        rsp_hold_q.data <= low_q;
      end else begin
        rsp_hold_q.data <= high_q;
      end
    end
  end

  // ==========================================================================
  // Setup and limit registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CONFIG_RESET;
      low_q <= LOW_RESET;
      high_q <= HIGH_RESET;
    end else begin
      if (wr_cfg) cfg_q <= {1'b1, lreq_q.data[14:0]};
      if (wr_low) low_q <= {lreq_q.data[15:LIMIT_LSB], LOW_FILL};
      if (wr_high) high_q <= {lreq_q.data[15:LIMIT_LSB], HIGH_FILL};
    end
  end

  assign gain_range_select = cfg_q[GAIN_LSB+:3];
  assign full_scale_span = span_mv(gain_range_select);
  assign rate_select = cfg_q[RATE_LSB+:3];
  assign rate_sps = sps(rate_select);

  // ==========================================================================
  // Conversion sequencing
  logic conv_start_q;
  assign start_req = (!cfg_q[MODE_BIT]) || (wr_cfg && lreq_q.data[START_BIT]);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= CONV_IDLE;
      conv_start_q <= 1'b0;
      result_q <= '0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        CONV_IDLE: begin
          if (start_req) begin
            state_q <= CONV_RUN;
            conv_start_q <= 1'b1;
          end
        end
        CONV_RUN: begin
          if (conv_done) begin
            state_q <= CONV_IDLE;
            result_q <= {conv_result, 4'h0};
          end
        end
        default: state_q <= CONV_IDLE;
      endcase
    end
  end
  assign conv_start = conv_start_q;
  // Powered down between single-shot conversions
  assign converter_on = state_q == CONV_RUN || !cfg_q[MODE_BIT];

  // ==========================================================================
  // Threshold comparator
  logic conv_evt, above, below, exceed, release_c, alert_set, alert_clr;
  logic [2:0] cnt_q;
  logic [1:0] que;
  assign que = cfg_q[QUE_LSB+:2];
  assign conv_evt = state_q == CONV_RUN && conv_done;
  assign above = $signed(conv_result) > $signed(high_q[15:LIMIT_LSB]);
  assign below = $signed(conv_result) < $signed(low_q[15:LIMIT_LSB]);
  assign exceed = cfg_q[STYLE_BIT] ? (above || below) : above;
  assign release_c = cfg_q[STYLE_BIT] ? !exceed : below;
  assign alert_set = conv_evt && exceed && que != QUE_OFF
    && (cnt_q + 3'h1) >= need(que);
  assign alert_clr = que == QUE_OFF
    || (!cfg_q[LATCH_BIT] && conv_evt && release_c)
    || (cfg_q[LATCH_BIT] && (rd_result || ara_hit));

  // Consecutive exceeding results, saturating at four
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
    end else if (que == QUE_OFF) begin
      cnt_q <= 3'h0;
    end else if (conv_evt) begin
      cnt_q <= exceed ? ((cnt_q == 3'h4) ? cnt_q : cnt_q + 3'h1) : 3'h0;
    end
  end

  // Alert flag, a new setting event wins over a clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) alert_q <= 1'b0;
    else if (alert_set) alert_q <= 1'b1;
    else if (alert_clr) alert_q <= 1'b0;
  end

  // ==========================================================================
  // Ready indicator and pin driver
  logic rdy_mode, rdy_act, active;
  logic [8:0] rdy_cnt_q;
  logic pin_q, oe_q;
  assign rdy_mode = high_q[15] && !low_q[15];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rdy_cnt_q <= '0;
    else if (conv_evt && !cfg_q[MODE_BIT]) rdy_cnt_q <= 9'(RDY_PULSE_CYC);
    else if (rdy_cnt_q != 9'h000) rdy_cnt_q <= rdy_cnt_q - 9'h001;
  end
  assign rdy_act = cfg_q[MODE_BIT] ? (state_q == CONV_IDLE) : (rdy_cnt_q != 9'h000);
  assign active = rdy_mode ? rdy_act : alert_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      pin_q <= cfg_q[POL_BIT] ? active : !active;
      oe_q <= que != QUE_OFF;
    end
  end
  assign alert_o = pin_q;
  assign alert_oe = oe_q;

  // ==========================================================================
  // Checks
  sequence s_exceed_run;
    conv_evt && exceed && que == 2'h2 ##1 (!conv_evt)[*1];
  endsequence
  a_gain_span: assert property (@(posedge core_clk) disable iff (!nrst)
    gain_range_select == 3'h0 |-> full_scale_span == 13'h1800) else $error("span wrong");
  a_cont_restart: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == CONV_IDLE && !cfg_q[MODE_BIT] |=> conv_start) else $error("no restart");
  a_rate_map: assert property (@(posedge core_clk) disable iff (!nrst)
    rate_select == 3'h4 |-> rate_sps == 12'h640) else $error("rate wrong");
  a_pin_level: assert property (@(posedge core_clk) disable iff (!nrst)
    !cfg_q[POL_BIT] && active && $stable(cfg_q) |=> !alert_o) else $error("level wrong");
  a_auto_release: assert property (@(posedge core_clk) disable iff (!nrst)
    !cfg_q[LATCH_BIT] && conv_evt && release_c && !alert_set |=> !alert_q)
    else $error("no release");
  a_latch_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    alert_q && cfg_q[LATCH_BIT] && !rd_result && !resp_evt && que != QUE_OFF
    && $stable(cfg_q) |=> alert_q) else $error("latch lost");
  a_resp_addr: assert property (@(posedge core_clk) disable iff (!nrst)
    ara_hit |=> rsp_hold_q.hit && rsp_hold_q.data[6:0] == addr_s2_q) else $error("bad resp");
  a_que_float: assert property (@(posedge core_clk) disable iff (!nrst)
    que == QUE_OFF |=> !alert_oe && !alert_q) else $error("pin not floated");
  a_queue_four: assert property (@(posedge core_clk) disable iff (!nrst)
    s_exceed_run |-> cnt_q != 3'h0) else $error("queue count lost");
  a_set_count: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(alert_q) |-> $past(cnt_q) + 3'h1 >= need($past(que))) else $error("early alert");
  a_rdy_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_evt && !cfg_q[MODE_BIT] |=> rdy_cnt_q == 9'(RDY_PULSE_CYC)) else $error("no pulse");
  a_busy_start: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == CONV_RUN && !conv_done |=> !conv_start) else $error("start while busy");
endmodule

//--- testbench/conv_core_model.sv
// Behavioural conversion core that answers the setup block's start pulses.
// Assumes core_clk and nrst are shared with the block under test.
`timescale 1ns/100ps
module conv_core_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic conv_start,
  input wire logic [11:0] next_result,
  input wire logic [9:0] delay_cyc,
  output logic conv_done,
  output logic [11:0] conv_result
);
  logic busy_q;
  logic [9:0] cnt_q;
  // ==========================================================================
  // Conversion timing
  // Result lines toggle outside the done cycle so a stale value never looks valid
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 10'h000;
      conv_done <= 1'b0;
      conv_result <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy_q <= 1'b1;
        cnt_q <= delay_cyc;
      end else if (busy_q && cnt_q == 10'h000) begin
        busy_q <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= next_result;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 10'h001;
      end
    end
  end
endmodule

//--- testbench/adc_setup_alert_tb.sv
// Self-checking bench for the setup register and alert comparator.
// Assumes the conversion core model answers every start pulse.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module adc_setup_alert_tb;
  import adc_cfg_pkg::*;
  logic [6:0] own_addr = 7'h2B; // Arbitrary strap value, moved once in the latch test
  logic core_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0;
  link_req_s req = '0;
  link_rsp_s rsp, r;
  logic req_ready, rsp_valid, conv_start, conv_done, converter_on, alert_o, alert_oe;
  logic [11:0] conv_result, rate_sps, nres = 12'h000;
  logic [9:0] dly = 10'h014;
  logic [2:0] gain_range_select, rate_select;
  logic [12:0] full_scale_span;
  logic [15:0] cfg;
  int bad_count = 0, n_tests = 0, starts = 0;
  logic [11:0] rtab [8] = '{12'h080, 12'h0FA, 12'h1EA, 12'h398, 12'h640, 12'h960, 12'hCE4, 12'hCE4};
  logic [12:0] stab [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400, 13'h0000, 13'h0000,
    13'h0100, 13'h0100};
  // Clocks with unrelated phase
  always #12.5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  // Count start pulses seen by the core
  always @(posedge core_clk) if (conv_start === 1'b1) starts++;
  adc_setup_alert uut (.core_clk(core_clk), .nrst(nrst), .link_clk(link_clk),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .dev_addr(own_addr), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .converter_on(converter_on),
    .gain_range_select(gain_range_select), .full_scale_span(full_scale_span),
    .rate_select(rate_select), .rate_sps(rate_sps), .alert_o(alert_o), .alert_oe(alert_oe));
  conv_core_model core (.core_clk(core_clk), .nrst(nrst), .conv_start(conv_start),
    .next_result(nres), .delay_cyc(dly), .conv_done(conv_done), .conv_result(conv_result));
  // ==========================================================================
  // Access tasks
  function automatic logic [15:0] cw(input logic [2:0] g, input logic m, input logic [2:0] rt,
      input logic st, input logic pl, input logic lt, input logic [1:0] q);
    return {4'h0, g, m, rt, st, pl, lt, q};
  endfunction
  task automatic xfer(input req_kind_e k, input logic [1:0] p, input logic [15:0] d);
    int i;
    i = 0;
    @(negedge link_clk);
    while (req_ready !== 1'b1 && i < 50) begin
      @(negedge link_clk);
      i++;
    end
    // A port that never frees up counts as a mismatch
    if (req_ready !== 1'b1) begin
      bad_count++;
      summarize();
    end
    req_valid = 1'b1;
    req = '{kind: k, ptr: p, data: d};
    @(negedge link_clk);
    req_valid = 1'b0;
    req.data = ~d;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 60) begin
      @(negedge link_clk);
      i++;
    end
    if (rsp_valid !== 1'b1) begin
      bad_count++;
      summarize();
    end
    r = rsp;
  endtask
  task automatic core_wait(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_done();
    int i;
    i = 0;
    while (conv_done !== 1'b1 && i < 2000) begin
      @(negedge core_clk);
      i++;
    end
    if (conv_done !== 1'b1) begin
      bad_count++;
      summarize();
    end
    core_wait(3);
  endtask
  task automatic convert(input logic [11:0] v);
    nres = v;
    xfer(REQ_WRITE, PTR_CONFIG, cfg | 16'h8000);
    wait_done();
  endtask
  task automatic pin(input logic act, input logic pl);
    `CHK("alert_oe", 1'b1, alert_oe)
    `CHK("alert_o", act ? pl : ~pl, alert_o)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge link_clk);
    xfer(REQ_READ, PTR_CONFIG, 16'h0000);
    `CHK("setup reset", 16'h8583, r.data)
    `CHK("oe reset", 1'b0, alert_oe)
    `CHK("span reset", 13'h0800, full_scale_span)
    `CHK("rate reset", 12'h640, rate_sps)
    xfer(REQ_READ, PTR_HIGH, 16'h0000);
    `CHK("high reset", 16'h7FFF, r.data)
    xfer(REQ_READ, PTR_LOW, 16'h0000);
    `CHK("low reset", 16'h8000, r.data)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      cfg = cw(i[2:0], 1'b1, i[2:0], 1'b0, 1'b0, 1'b0, 2'h3);
      xfer(REQ_WRITE, PTR_CONFIG, cfg);
      xfer(REQ_READ, PTR_CONFIG, 16'h0000);
      `CHK("setup rd", cfg | 16'h8000, r.data)
      `CHK("rate", rtab[i], rate_sps)
      `CHK("rate sel", i[2:0], rate_select)
      `CHK("gain sel", i[2:0], gain_range_select)
      if (i < 4 || i > 5) `CHK("span", stab[i], full_scale_span)
    end
    $display("test decode done");
    cfg = cw(3'h2, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0, 2'h3);
    dly = 10'h0C8;
    nres = 12'h123;
    starts = 0;
    xfer(REQ_WRITE, PTR_CONFIG, cfg | 16'h8000);
    xfer(REQ_READ, PTR_CONFIG, 16'h0000);
    `CHK("busy status", cfg, r.data)
    `CHK("on busy", 1'b1, converter_on)
    xfer(REQ_WRITE, PTR_CONFIG, cfg | 16'h8000);
    wait_done();
    `CHK("one start", 1, starts)
    `CHK("off idle", 1'b0, converter_on)
    `CHK("oe off", 1'b0, alert_oe)
    xfer(REQ_READ, PTR_RESULT, 16'h0000);
    `CHK("result", 16'h1230, r.data)
    dly = 10'h014;
    $display("test start done");
    xfer(REQ_WRITE, PTR_LOW, 16'h080F);
    xfer(REQ_WRITE, PTR_HIGH, 16'h1000);
    xfer(REQ_READ, PTR_HIGH, 16'h0000);
    `CHK("high rd", 16'h100F, r.data)
    xfer(REQ_READ, PTR_LOW, 16'h0000);
    `CHK("low rd", 16'h0800, r.data)
    for (int q = 0; q < 3; q++) begin
      cfg = cw(3'h2, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0, q[1:0]);
      convert(12'h050);
      for (int k = 1; k <= (1 << q); k++) begin
        convert(12'h200);
        pin(k == (1 << q), 1'b0);
      end
      convert(12'h0C0);
      pin(1'b1, 1'b0);
      convert(12'h050);
      pin(1'b0, 1'b0);
    end
    $display("test queue done");
    cfg = cw(3'h2, 1'b1, 3'h4, 1'b1, 1'b1, 1'b0, 2'h0);
    convert(12'hF00);
    pin(1'b1, 1'b1);
    convert(12'h0C0);
    pin(1'b0, 1'b1);
    convert(12'h300);
    pin(1'b1, 1'b1);
    $display("test window done");
    cfg = cw(3'h2, 1'b1, 3'h4, 1'b0, 1'b0, 1'b1, 2'h0);
    convert(12'h200);
    convert(12'h050);
    pin(1'b1, 1'b0);
    xfer(REQ_WRITE, PTR_RESULT, 16'h1234);
    xfer(REQ_READ, PTR_RESULT, 16'h0000);
    `CHK("result rd", 16'h0500, r.data)
    core_wait(4);
    pin(1'b0, 1'b0);
    convert(12'h200);
    xfer(REQ_ALERT_RESP, PTR_RESULT, 16'h0000);
    `CHK("resp hit", 1'b1, r.hit)
    `CHK("resp addr", {9'h000, own_addr}, r.data)
    // New strap value settles through the synchroniser before the next response
    own_addr = 7'h35;
    core_wait(4);
    pin(1'b0, 1'b0);
    xfer(REQ_ALERT_RESP, PTR_RESULT, 16'h0000);
    `CHK("resp none", 1'b0, r.hit)
    `CHK("resp addr2", {9'h000, own_addr}, r.data)
    $display("test latch done");
    xfer(REQ_WRITE, PTR_LOW, 16'h0000);
    xfer(REQ_WRITE, PTR_HIGH, 16'h8000);
    cfg = cw(3'h2, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0, 2'h0);
    xfer(REQ_WRITE, PTR_CONFIG, cfg);
    core_wait(4);
    pin(1'b1, 1'b0);
    dly = 10'h0C8;
    xfer(REQ_WRITE, PTR_CONFIG, cfg | 16'h8000);
    core_wait(20);
    pin(1'b0, 1'b0);
    wait_done();
    pin(1'b1, 1'b0);
    dly = 10'h014;
    starts = 0;
    cfg = cw(3'h2, 1'b0, 3'h4, 1'b0, 1'b0, 1'b0, 2'h0);
    xfer(REQ_WRITE, PTR_CONFIG, cfg);
    core_wait(100);
    `CHK("cont on", 1'b1, converter_on)
    `CHK("cont starts", 1'b1, starts >= 2)
    wait_done();
    pin(1'b1, 1'b0);
    // Slow conversions so the ready pulse must end between two results
    dly = 10'h3FF;
    wait_done();
    core_wait(340);
    pin(1'b0, 1'b0);
    wait_done();
    pin(1'b1, 1'b0);
    $display("test ready done");
    summarize();
  end
endmodule
